// ### rtl/scp_pkg.sv
// Shared constants and types for the system clock and power mode controller.
package scp_pkg;

	// Register offsets on the plain register port
	localparam logic [3:0] REG_SYS_MODE   = 4'h0;
	localparam logic [3:0] REG_WDT_CTRL   = 4'h1;
	localparam logic [3:0] REG_PWR_CTRL   = 4'h2;
	localparam logic [3:0] REG_MODE_STAT  = 4'h3;

	// Field positions in the system mode register
	localparam int SYSTEM_MODE_REGISTER_DIV_LSB   = 5;
	localparam int SYSTEM_MODE_REGISTER_FAST_WAKE = 4;
	localparam int SYSTEM_MODE_REGISTER_LF_RDY    = 3;
	localparam int SYSTEM_MODE_REGISTER_HF_RDY    = 2;
	localparam int SYSTEM_MODE_REGISTER_IDLE      = 1;
	localparam int SYSTEM_MODE_REGISTER_HL_SEL    = 0;

	// Field positions in the watchdog and power control registers
	localparam int WATCHDOG_CONTROL_REGISTER_KEEP_SYS  = 0;
	localparam int WATCHDOG_CONTROL_REGISTER_WDT_ON    = 1;
	localparam int PWR_LVD_EN     = 0;

	// Reset values
	localparam logic [7:0] SYSTEM_MODE_REGISTER_RST   = 8'h03;
	localparam logic       KEEP_RST   = 1'b0;
	localparam logic       WDT_ON_RST = 1'b0;
	localparam logic       LVD_RST    = 1'b0;

	// High-speed source choices of the configuration option
	localparam logic [1:0] HS_CRYSTAL = 2'h0;
	localparam logic [1:0] HS_EXT_RC  = 2'h1;
	localparam logic [1:0] HS_EXT_CLK = 2'h2;
	localparam logic [1:0] HS_INT_RC  = 2'h3;

	// Divider codes below this value select the low-frequency clock
	localparam logic [2:0] DIV_FIRST_HF = 3'h2;

	// Wake-up waits, counted in ticks of the source being restarted
	localparam logic [10:0] WAKE_CRYSTAL = 11'h400;
	localparam logic [10:0] WAKE_RC      = 11'h010;
	localparam logic [10:0] WAKE_INTERNAL_SLOW_RC    = 11'h002;
	localparam logic [10:0] WAKE_WARM    = 11'h002;

	// Operating modes; MODE_WAKE is the restart wait before a run mode, after a low-power mode or a slow to normal switch
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_SLOW,
		MODE_SLEEP_DEEP,
		MODE_SLEEP_LIGHT,
		MODE_IDLE_STOP,
		MODE_IDLE_RUN,
		MODE_WAKE
	} scp_mode_t;

endpackage

// ### rtl/scp_clock_ctrl.sv
// System clock selection and operating mode sequencer.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns

// How it works
// - System clock from fast or slow source
// - Fast source picked among four oscillators
// - Slow source is crystal or slow RC
// - Normal mode divides fast clock 1 to 64
// - Substitute and time-base clocks from slow oscillators
// - Substitute clock drives system during fast wake
// - Watchdog clock: substitute or system over four
// - Time-base clock feeds both time-base timers
// - Six modes; CPU stops outside run modes and fast wake
// - Switching to slow clock stops fast oscillator
// - Slow mode runs CPU, fast clock off
// - Halt without idle bit enters sleep
// - Deep sleep stops substitute, watchdog clocks
// - Voltage detect enabled blocks deep sleep
// - Light sleep keeps substitute clock when needed
// - Halt, idle, no keep: stopped idle
// - Stopped idle stops system clock and fast oscillator
// - Stopped idle watchdog clock follows its source
// - Halt, idle, keep: running idle
// - Running idle keeps system clock running
// - Divider code decodes slow or fast divisions
// - Select bit high picks undivided fast clock
// - Reset: idle and select high, divider zero
module scp_clock_ctrl
	import scp_pkg::*;
(
	input  wire logic       clk_i,            // Block clock, 250 MHz
	input  wire logic       reset_n_i,        // Async reset, active low
	input  wire logic [3:0] addr_i,           // Register address
	input  wire logic [7:0] wr_data_i,        // Register write data
	input  wire logic       wr_en_i,          // Write strobe
	input  wire logic       rd_en_i,          // Read strobe
	output logic      [7:0] rd_data_o,        // Read data, cycle after strobe
	input  wire logic       halt_i,           // CPU executed halt, pulse
	input  wire logic       wake_i,           // Wake-up event, pulse
	input  wire logic       hs_crystal_i,     // Fast crystal oscillator
	input  wire logic       hs_ext_rc_i,      // External RC oscillator
	input  wire logic       hs_ext_clk_i,     // External clock input
	input  wire logic       hs_int_rc_i,      // Internal fast RC
	input  wire logic       ls_crystal_i,     // Slow crystal oscillator
	input  wire logic       ls_int_rc_i,      // Internal slow RC
	input  wire logic [1:0] cfg_hs_src_i,     // Option: fast source
	input  wire logic       cfg_lf_rc_i,      // Option: slow clock from RC
	input  wire logic       cfg_sub_rc_i,     // Option: substitute from RC
	input  wire logic       cfg_tbc_rc_i,     // Option: time base from RC
	input  wire logic       cfg_wdt_sub_i,    // Option: watchdog on substitute
	output logic            cpu_clk_en_o,     // CPU clock tick
	output logic            sys_clk_en_o,     // System clock tick
	output logic            sub_clk_en_o,     // Substitute clock tick
	output logic            wdt_clk_en_o,     // Watchdog clock tick
	output logic            tbc_clk_en_o,     // Time-base clock tick
	output logic            wdt_enable_o,     // Watchdog function enabled
	output logic            hf_osc_en_o,      // Fast oscillator enable
	output logic            lf_osc_en_o       // Slow oscillators enable
);

	// Synchroniser stages for the oscillator and option inputs
	logic [12:0] meta_ff;
	logic [12:0] sync_ff;
	logic [5:0]  osc_last_ff;
	logic [5:0]  osc_edge;

	// Register state
	logic [7:0] system_mode_register_ff;
	logic       keep_sys_ff;
	logic       wdt_on_ff;
	logic       lvd_en_ff;
	logic [7:0] rd_data_ff;

	// Mode sequencer state
	scp_mode_t  mode_ff;
	scp_mode_t  from_ff;
	logic [10:0] wake_cnt_ff;
	logic [10:0] wake_need_ff;
	logic        fast_wake_ff;

	// Clock generation state
	logic [5:0] div_cnt_ff;
	logic [1:0] wdt_div_ff;
	logic       cpu_en_ff;
	logic       sys_en_ff;
	logic       sub_en_ff;
	logic       wdt_tick_ff;
	logic       tbc_en_ff;
	logic       wdt_enable_ff;
	logic       hf_osc_ff;
	logic       lf_osc_ff;

	// Decoded control terms
	logic [2:0] div_sel;
	logic       hl_sel;
	logic       sys_src_hf;
	logic       sub_needed;
	logic       is_run;
	logic       hf_on;
	logic       sub_on;
	logic       hf_tick;
	logic       lf_tick;
	logic       sub_tick;
	logic       tbc_tick;
	logic       div_tick;
	logic [5:0] div_mask;
	logic       sys_tick;
	logic       tgt_tick;
	logic       wake_tick;
	logic       wake_done;
	scp_mode_t  run_target;

	// Pins come from oscillator domains: two flops before any use
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_ff <= 13'h0000;
			sync_ff <= 13'h0000;
		end else begin
			meta_ff <= {cfg_wdt_sub_i, cfg_tbc_rc_i, cfg_sub_rc_i, cfg_lf_rc_i,
				cfg_hs_src_i, ls_int_rc_i, ls_crystal_i, hs_int_rc_i,
				hs_ext_clk_i, hs_ext_rc_i, hs_crystal_i, 1'b0};
			sync_ff <= meta_ff;
		end
	end

	// Rising edges of the synchronised oscillators become ticks
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			osc_last_ff <= 6'h00;
		end else begin
			osc_last_ff <= sync_ff[6:1];
		end
	end

	assign osc_edge = sync_ff[6:1] & ~osc_last_ff;

	// Source selection from the configuration options
	always_comb begin
		case (sync_ff[8:7])
			HS_CRYSTAL: hf_tick = osc_edge[0];
			HS_EXT_RC:  hf_tick = osc_edge[1];
			HS_EXT_CLK: hf_tick = osc_edge[2];
			default:    hf_tick = osc_edge[3];
		endcase
	end

	assign lf_tick  = sync_ff[9]  ? osc_edge[5] : osc_edge[4];
	assign sub_tick = sync_ff[10] ? osc_edge[5] : osc_edge[4];
	assign tbc_tick = sync_ff[11] ? osc_edge[5] : osc_edge[4];

	// Clock select decode
	assign div_sel    = system_mode_register_ff[SYSTEM_MODE_REGISTER_DIV_LSB +: 3];
	assign hl_sel     = system_mode_register_ff[SYSTEM_MODE_REGISTER_HL_SEL];
	assign sys_src_hf = hl_sel || (div_sel >= DIV_FIRST_HF);
	assign run_target = sys_src_hf ? MODE_NORMAL : MODE_SLOW;
	assign sub_needed = lvd_en_ff || (wdt_on_ff && sync_ff[12]);
	assign is_run     = (mode_ff == MODE_NORMAL) || (mode_ff == MODE_SLOW);

	// Fast oscillator only runs while something needs it
	assign hf_on = (mode_ff == MODE_NORMAL)
		|| ((mode_ff == MODE_IDLE_RUN) && sys_src_hf)
		|| ((mode_ff == MODE_WAKE) && sys_src_hf);
	assign sub_on = (mode_ff != MODE_SLEEP_DEEP);

	// Divider mask: code 2 gives /64 down to code 7 giving /2
	always_comb begin
		case (div_sel)
			3'h2:    div_mask = 6'h3F;
			3'h3:    div_mask = 6'h1F;
			3'h4:    div_mask = 6'h0F;
			3'h5:    div_mask = 6'h07;
			3'h6:    div_mask = 6'h03;
			3'h7:    div_mask = 6'h01;
			default: div_mask = 6'h00;
		endcase
	end

	assign div_tick = hf_tick && ((div_cnt_ff & div_mask) == div_mask);

	// System clock tick before mode gating
	always_comb begin
		if (!sys_src_hf) begin
			sys_tick = lf_tick;
		end else if (hl_sel) begin
			sys_tick = hf_on && hf_tick;
		end else begin
			sys_tick = hf_on && div_tick;
		end
	end

	assign tgt_tick  = sys_src_hf ? (hf_on && hf_tick) : lf_tick;
	assign wake_tick = (mode_ff == MODE_WAKE) && fast_wake_ff && sub_tick;
	assign wake_done = tgt_tick && ((wake_cnt_ff + 11'h001) >= wake_need_ff);

	// Divider counter runs on the fast ticks
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_cnt_ff <= 6'h00;
		end else if (hf_on && hf_tick) begin
			div_cnt_ff <= div_cnt_ff + 6'h01;
		end
	end

	// Restart wait depends on which oscillator was stopped
	function automatic logic [10:0] wake_need(input scp_mode_t from, input logic tgt_hf);
		logic [10:0] need;
		need = WAKE_WARM;
		if (from == MODE_IDLE_RUN) begin
			need = WAKE_WARM;
		end else if (tgt_hf) begin
			need = (sync_ff[8:7] == HS_CRYSTAL) ? WAKE_CRYSTAL : WAKE_RC;
		end else if (sync_ff[9]) begin
			need = WAKE_INTERNAL_SLOW_RC;
		end else if (from == MODE_SLEEP_DEEP) begin
			need = WAKE_CRYSTAL;
		end
		return need;
	endfunction

	// Mode sequencer
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_ff      <= MODE_NORMAL;
			from_ff      <= MODE_NORMAL;
			wake_cnt_ff  <= 11'h000;
			wake_need_ff <= WAKE_WARM;
			fast_wake_ff <= 1'b0;
		end else begin
			case (mode_ff)
				MODE_NORMAL, MODE_SLOW: begin
					if (halt_i) begin
						if (system_mode_register_ff[SYSTEM_MODE_REGISTER_IDLE]) begin
							mode_ff <= keep_sys_ff ? MODE_IDLE_RUN : MODE_IDLE_STOP;
						end else begin
							// Deep sleep refused while voltage detect is on
							mode_ff <= sub_needed ? MODE_SLEEP_LIGHT : MODE_SLEEP_DEEP;
						end
					end else if (mode_ff != run_target) begin
						if (sys_src_hf) begin
							// Fast oscillator was off: wait for it
							mode_ff      <= MODE_WAKE;
							from_ff      <= mode_ff;
							wake_cnt_ff  <= 11'h000;
							wake_need_ff <= wake_need(mode_ff, 1'b1);
							fast_wake_ff <= 1'b0;
						end else begin
							mode_ff <= MODE_SLOW;
						end
					end
				end
				MODE_SLEEP_DEEP, MODE_SLEEP_LIGHT, MODE_IDLE_STOP, MODE_IDLE_RUN: begin
					if (wake_i) begin
						mode_ff      <= MODE_WAKE;
						from_ff      <= mode_ff;
						wake_cnt_ff  <= 11'h000;
						wake_need_ff <= wake_need(mode_ff, sys_src_hf);
						// Fast wake only from light sleep and stopped idle
						fast_wake_ff <= system_mode_register_ff[SYSTEM_MODE_REGISTER_FAST_WAKE] && sys_src_hf
							&& (sync_ff[8:7] == HS_CRYSTAL)
							&& ((mode_ff == MODE_SLEEP_LIGHT)
							|| (mode_ff == MODE_IDLE_STOP));
					end
				end
				MODE_WAKE: begin
					if (wake_done) begin
						mode_ff <= run_target;
					end else if (tgt_tick) begin
						wake_cnt_ff <= wake_cnt_ff + 11'h001;
					end
				end
				default: begin
					mode_ff <= run_target;
				end
			endcase
		end
	end

	// Watchdog divide-by-four counts system ticks in clock-running modes
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wdt_div_ff <= 2'h0;
		end else if ((is_run || (mode_ff == MODE_IDLE_RUN)) && sys_tick) begin
			wdt_div_ff <= wdt_div_ff + 2'h1;
		end
	end

	// Gated clock ticks, registered so every output leaves a flop
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cpu_en_ff   <= 1'b0;
			sys_en_ff   <= 1'b0;
			sub_en_ff   <= 1'b0;
			wdt_tick_ff <= 1'b0;
			tbc_en_ff   <= 1'b0;
		end else begin
			cpu_en_ff <= (is_run && sys_tick) || wake_tick;
			sys_en_ff <= ((is_run || (mode_ff == MODE_IDLE_RUN)) && sys_tick)
				|| wake_tick;
			sub_en_ff <= sub_on && sub_tick;
			tbc_en_ff <= (mode_ff != MODE_SLEEP_DEEP)
				&& (mode_ff != MODE_SLEEP_LIGHT) && tbc_tick;
			if (sync_ff[12]) begin
				wdt_tick_ff <= sub_on && sub_tick;
			end else begin
				// System over four stops with the system clock
				wdt_tick_ff <= (is_run || (mode_ff == MODE_IDLE_RUN)) && sys_tick
					&& (wdt_div_ff == 2'h3);
			end
		end
	end

	// Oscillator enables and watchdog function gate
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hf_osc_ff     <= 1'b1;
			lf_osc_ff     <= 1'b1;
			wdt_enable_ff <= 1'b0;
		end else begin
			hf_osc_ff     <= hf_on;
			// Slow oscillators rest only in deep sleep; wake restarts them
			lf_osc_ff     <= (mode_ff != MODE_SLEEP_DEEP);
			wdt_enable_ff <= wdt_on_ff && (mode_ff != MODE_SLEEP_DEEP);
		end
	end

	// Software-visible control registers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			system_mode_register_ff     <= SYSTEM_MODE_REGISTER_RST;
			keep_sys_ff <= KEEP_RST;
			wdt_on_ff   <= WDT_ON_RST;
			lvd_en_ff   <= LVD_RST;
		end else if (wr_en_i) begin
			case (addr_i)
				REG_SYS_MODE: begin
					// Ready flags are read-only and never stored
					system_mode_register_ff <= wr_data_i & 8'hF3;
				end
				REG_WDT_CTRL: begin
					keep_sys_ff <= wr_data_i[WATCHDOG_CONTROL_REGISTER_KEEP_SYS];
					wdt_on_ff   <= wr_data_i[WATCHDOG_CONTROL_REGISTER_WDT_ON];
				end
				REG_PWR_CTRL: begin
					lvd_en_ff <= wr_data_i[PWR_LVD_EN];
				end
				default: begin
				end
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_ff <= 8'h00;
		end else if (rd_en_i) begin
			case (addr_i)
				REG_SYS_MODE: begin
					rd_data_ff <= system_mode_register_ff & 8'hF3;
					rd_data_ff[SYSTEM_MODE_REGISTER_LF_RDY] <= lf_osc_ff && (mode_ff != MODE_WAKE);
					rd_data_ff[SYSTEM_MODE_REGISTER_HF_RDY] <= hf_on && (mode_ff != MODE_WAKE);
				end
				REG_WDT_CTRL: rd_data_ff <= {6'h00, wdt_on_ff, keep_sys_ff};
				REG_PWR_CTRL: rd_data_ff <= {7'h00, lvd_en_ff};
				REG_MODE_STAT: rd_data_ff <= {5'h00, mode_ff};
				default: rd_data_ff <= 8'h00;
			endcase
		end else begin
			rd_data_ff <= 8'h00;
		end
	end

	assign rd_data_o    = rd_data_ff;
	assign cpu_clk_en_o = cpu_en_ff;
	assign sys_clk_en_o = sys_en_ff;
	assign sub_clk_en_o = sub_en_ff;
	assign wdt_clk_en_o = wdt_tick_ff;
	assign tbc_clk_en_o = tbc_en_ff;
	assign wdt_enable_o = wdt_enable_ff;
	assign hf_osc_en_o  = hf_osc_ff;
	assign lf_osc_en_o  = lf_osc_ff;

	// Checks on the mode sequencer and clock gating
	sequence s_halt_run;
		is_run && halt_i;
	endsequence

	property p_sleep_entry;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_halt_run and (!system_mode_register_ff[SYSTEM_MODE_REGISTER_IDLE] && !sub_needed) |=> (mode_ff == MODE_SLEEP_DEEP);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("halt did not sleep");

	property p_lvd_blocks_deep;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_halt_run and (lvd_en_ff && !system_mode_register_ff[SYSTEM_MODE_REGISTER_IDLE]) |=> (mode_ff == MODE_SLEEP_LIGHT);
	endproperty
	a_lvd_blocks_deep: assert property (p_lvd_blocks_deep) else $error("deep sleep with lvd");

	property p_idle_stop_entry;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_halt_run and (system_mode_register_ff[SYSTEM_MODE_REGISTER_IDLE] && !keep_sys_ff) |=> (mode_ff == MODE_IDLE_STOP);
	endproperty
	a_idle_stop_entry: assert property (p_idle_stop_entry) else $error("no stopped idle");

	property p_idle_run_entry;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_halt_run and (system_mode_register_ff[SYSTEM_MODE_REGISTER_IDLE] && keep_sys_ff) |=> (mode_ff == MODE_IDLE_RUN);
	endproperty
	a_idle_run_entry: assert property (p_idle_run_entry) else $error("no running idle");

	property p_cpu_stopped;
		@(posedge clk_i) disable iff (!reset_n_i)
		(!is_run && (mode_ff != MODE_WAKE)) [*2] |-> !cpu_en_ff;
	endproperty
	a_cpu_stopped: assert property (p_cpu_stopped) else $error("cpu ticks while stopped");

	property p_deep_quiet;
		@(posedge clk_i) disable iff (!reset_n_i)
		(mode_ff == MODE_SLEEP_DEEP) [*2] |-> (!sub_en_ff && !wdt_tick_ff && !wdt_enable_ff);
	endproperty
	a_deep_quiet: assert property (p_deep_quiet) else $error("clocks alive in deep sleep");

	property p_slow_hf_off;
		@(posedge clk_i) disable iff (!reset_n_i)
		(mode_ff == MODE_SLOW) [*2] |-> !hf_osc_ff;
	endproperty
	a_slow_hf_off: assert property (p_slow_hf_off) else $error("fast osc on in slow mode");

	property p_idle_stop_wdt;
		@(posedge clk_i) disable iff (!reset_n_i)
		((mode_ff == MODE_IDLE_STOP) && !sync_ff[12]) [*2] |-> !wdt_tick_ff && !sys_en_ff;
	endproperty
	a_idle_stop_wdt: assert property (p_idle_stop_wdt) else $error("idle wdt clock on");

endmodule

// ### testbench/scp_far_side_model.sv
// Far-side model: oscillators that follow their enables, and tick counters of the clock users.
`timescale 1ns/1ns
module scp_far_side_model (
	input  wire logic        clk_i,      // Bench clock
	input  wire logic        reset_n_i,  // Async reset, active low
	input  wire logic        hf_en_i,    // Fast oscillator enable
	input  wire logic        lf_en_i,    // Slow oscillator enable
	input  wire logic        clr_i,      // Clear the tick counters
	input  wire logic [4:0]  tick_i,     // Ticks: cpu, sys, sub, wdt, tbc
	output logic      [5:0]  osc_o,      // Fast 0..3, slow crystal 4, slow RC 5
	output logic      [15:0] cnt_o [5]   // Ticks seen since last clear
);
	// Each oscillator has its own half period, so a wrong source pick shows as a wrong rate
	for (genvar g = 0; g < 6; g++) begin : g_osc
		localparam int H = (g < 4) ? 3 + g : 8 + 2 * (g - 4);
		logic [3:0] ph_ff;
		logic       osc_ff;
		logic       on;
		assign on = (g < 4) ? hf_en_i : lf_en_i;
		assign osc_o[g] = osc_ff;
		// A disabled oscillator stands still low instead of running free
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i || !on) begin
				ph_ff  <= 4'h0;
				osc_ff <= 1'b0;
			end else if (ph_ff == 4'(H - 1)) begin
				ph_ff  <= 4'h0;
				osc_ff <= ~osc_ff;
			end else begin
				ph_ff <= ph_ff + 4'h1;
			end
		end
	end

	// Tick counters; windows are short, so no wrap handling
	for (genvar k = 0; k < 5; k++) begin : g_cnt
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i)
				cnt_o[k] <= 16'h0000;
			else if (clr_i)
				cnt_o[k] <= 16'h0000;
			else if (tick_i[k])
				cnt_o[k] <= cnt_o[k] + 16'h0001;
		end
	end
endmodule

// ### testbench/system_clock_power_mode_ctrl_bench.sv
// Self-checking bench for the system clock and power mode controller.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("unexpected %s exp %0h got %0h", nm, exp, got); end end
module system_clock_power_mode_ctrl_bench
	import scp_pkg::*;
;
	localparam int W = 1536;
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [3:0]  addr_i = 4'h0;
	logic [7:0]  wr_data_i = 8'h00;
	logic        wr_en_i = 1'b0;
	logic        rd_en_i = 1'b0;
	logic        halt_i = 1'b0;
	logic        wake_i = 1'b0;
	logic [1:0]  cfg_hs_src_i = 2'h0;
	logic        cfg_lf_rc_i = 1'b0;
	logic        cfg_sub_rc_i = 1'b0;
	logic        cfg_tbc_rc_i = 1'b0;
	logic        cfg_wdt_sub_i = 1'b0;
	logic        clr = 1'b0;
	logic [5:0]  osc;
	logic [4:0]  ticks;
	logic [15:0] cnt [5];
	logic [7:0]  rd_data_o;
	logic [7:0]  rd;
	logic        wdt_enable_o;
	logic        hf_osc_en_o;
	logic        lf_osc_en_o;
	int          miscompares = 0;
	int          total_checks = 0;

	// 250 MHz block clock
	always #2 clk_i = ~clk_i;

	scp_clock_ctrl u_dut (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .halt_i(halt_i),
		.wake_i(wake_i), .hs_crystal_i(osc[0]), .hs_ext_rc_i(osc[1]), .hs_ext_clk_i(osc[2]),
		.hs_int_rc_i(osc[3]), .ls_crystal_i(osc[4]), .ls_int_rc_i(osc[5]),
		.cfg_hs_src_i(cfg_hs_src_i), .cfg_lf_rc_i(cfg_lf_rc_i), .cfg_sub_rc_i(cfg_sub_rc_i),
		.cfg_tbc_rc_i(cfg_tbc_rc_i), .cfg_wdt_sub_i(cfg_wdt_sub_i), .cpu_clk_en_o(ticks[0]),
		.sys_clk_en_o(ticks[1]), .sub_clk_en_o(ticks[2]), .wdt_clk_en_o(ticks[3]),
		.tbc_clk_en_o(ticks[4]), .wdt_enable_o(wdt_enable_o), .hf_osc_en_o(hf_osc_en_o),
		.lf_osc_en_o(lf_osc_en_o));

	scp_far_side_model u_far (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .hf_en_i(hf_osc_en_o), .lf_en_i(lf_osc_en_o),
		.clr_i(clr), .tick_i(ticks), .osc_o(osc), .cnt_o(cnt));

	// Tick counts jitter by a tick or two at window edges
	function automatic logic near(input logic [15:0] got, input int e);
		return (int'(got) >= e - 2) && (int'(got) <= e + 2);
	endfunction

	function automatic scp_mode_t exp_mode(input logic [4:0] c);
		if (c[4])
			return c[3] ? MODE_IDLE_RUN : MODE_IDLE_STOP;
		return (c[2] | (c[1] & c[0])) ? MODE_SLEEP_LIGHT : MODE_SLEEP_DEEP;
	endfunction

	task automatic results();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic do_reset();
		reset_n_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rdr(input logic [3:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1;
		rd = rd_data_o;
	endtask

	task automatic pulse(input logic h);
		@(posedge clk_i);
		halt_i <= h;
		wake_i <= ~h;
		@(posedge clk_i);
		halt_i <= 1'b0;
		wake_i <= 1'b0;
	endtask

	task automatic measure(input int n);
		@(posedge clk_i);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Negative expectation means the rate is left open
	task automatic rate(input string nm, input int k, input int e);
		if (e == 0)
			`CHK(nm, 16'h0000, cnt[k])
		else if (e > 0)
			`CHK(nm, 1'b1, near(cnt[k], e))
	endtask

	task automatic wait_mode(input scp_mode_t m);
		rd = 8'hff;
		for (int i = 0; i < 6000 && rd[2:0] !== m; i++)
			rdr(REG_MODE_STAT);
		`CHK("mode reached", m, rd[2:0])
	endtask

	// Hang guard: the run needs about 80k cycles, so stop at 100k
	initial begin
		#400_000;
		miscompares++;
		results();
	end

	initial begin
		int         s;
		int         e_sys;
		int         e_sub;
		logic [2:0] code;
		logic [4:0] cs;
		scp_mode_t  m;
		logic [4:0] cases [6];
		cases = '{5'b00001, 5'b00100, 5'b00011, 5'b10000, 5'b10001, 5'b11000};
		s = $urandom(32'h5d5e9392);
		do_reset();
		// Reset values, refused writes and unmapped reads
		rdr(REG_SYS_MODE);
		`CHK("sys mode reset", SYSTEM_MODE_REGISTER_RST, rd & 8'hF3)
		rdr(REG_WDT_CTRL);
		`CHK("wdt ctrl reset", {6'h00, WDT_ON_RST, KEEP_RST}, rd)
		wr(4'hF, 8'($urandom));
		wr(REG_MODE_STAT, 8'h06);
		rdr(4'hF);
		`CHK("unmapped read", 8'h00, rd)
		rdr(REG_MODE_STAT);
		`CHK("mode after reset", MODE_NORMAL, rd[2:0])

		// Every fast source, plus slow system, substitute, time-base and watchdog sources
		for (int i = 0; i < 4; i++) begin
			cfg_hs_src_i <= 2'(i);
			cfg_sub_rc_i <= i[0];
			cfg_tbc_rc_i <= i[1];
			cfg_lf_rc_i <= i[0] ^ i[1];
			cfg_wdt_sub_i <= i[0];
			do_reset();
			measure(W);
			e_sys = W / (2 * (3 + i));
			e_sub = W / (i[0] ? 20 : 16);
			rate("sys undivided", 1, e_sys);
			rate("sub clock", 2, e_sub);
			rate("wdt clock", 3, i[0] ? e_sub : e_sys / 4);
			rate("tbc clock", 4, W / (i[1] ? 20 : 16));
			wr(REG_SYS_MODE, {2'b00, 1'($urandom), 5'h02});
			measure(W);
			`CHK("fast osc stopped", 1'b0, hf_osc_en_o)
			rate("cpu slow", 0, W / ((i[0] ^ i[1]) ? 20 : 16));
			rdr(REG_MODE_STAT);
			`CHK("slow mode", MODE_SLOW, rd[2:0])
			wr(REG_SYS_MODE, SYSTEM_MODE_REGISTER_RST);
			wait_mode(MODE_NORMAL);
		end

		// Divider codes 2 to 7 in turn from a random start on the crystal source
		cfg_hs_src_i <= HS_CRYSTAL;
		cfg_sub_rc_i <= 1'b0;
		cfg_tbc_rc_i <= 1'b0;
		cfg_lf_rc_i <= 1'b0;
		do_reset();
		s = $urandom_range(5);
		for (int j = 0; j < 6; j++) begin
			code = 3'(2 + (s + j) % 6);
			wr(REG_SYS_MODE, {code, 5'h02});
			measure(W);
			rate("sys divided", 1, W / (6 * (1 << (8 - code))));
		end

		// Halt into each low-power mode, then wake and resume
		for (int k = 0; k < 6; k++) begin
			cs = cases[k];
			cfg_wdt_sub_i <= cs[0];
			do_reset();
			wr(REG_PWR_CTRL, {7'h00, cs[2]});
			wr(REG_WDT_CTRL, {6'h00, cs[1], cs[3]});
			wr(REG_SYS_MODE, {3'h0, k == 1, 2'b00, cs[4], 1'b1});
			pulse(1'b1);
			m = exp_mode(cs);
			rdr(REG_MODE_STAT);
			`CHK("mode entry", m, rd[2:0])
			measure(W);
			rate("cpu stopped", 0, 0);
			rate("sys in low power", 1, m == MODE_IDLE_RUN ? W / 6 : 0);
			rate("sub in low power", 2, m == MODE_SLEEP_DEEP ? 0 : W / 16);
			rate("wdt in low power", 3, m == MODE_SLEEP_DEEP ? 0 : cs[0] ? W / 16 :
				m == MODE_IDLE_RUN ? W / 24 : m == MODE_IDLE_STOP ? 0 : -1);
			rate("tbc in low power", 4, (m == MODE_SLEEP_DEEP || m == MODE_SLEEP_LIGHT) ?
				0 : W / 16);
			`CHK("wdt enable", cs[1] & (m != MODE_SLEEP_DEEP), wdt_enable_o)
			`CHK("slow osc enable", m != MODE_SLEEP_DEEP, lf_osc_en_o)
			rdr(REG_PWR_CTRL);
			`CHK("lvd readback", {7'h00, cs[2]}, rd)
			pulse(1'b0);
			if (k == 1) begin
				measure(256);
				`CHK("fast wake cpu", 1'b1, cnt[0] > 16'h0000)
			end
			wait_mode(MODE_NORMAL);
			measure(W);
			rate("cpu resumed", 0, W / 6);
		end
		results();
	end
endmodule
